// >>> verilog/i2c_master_engine.sv
// i2c master engine with general call and address monitor
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module i2c_master_engine (
	// clock and reset
	input  wire logic               clock,
	input  wire logic               resetn,
	// register port
	input  wire i2cm_pkg::reg_req_t req,
	output logic [15:0]             rdata,
	// chip power state
	input  wire logic               sleep,
	// bus lines
	input  wire i2cm_pkg::line_in_t lines_in,
	output i2cm_pkg::line_out_t     lines_out,
	output logic                    slew_control_disable,
	// event pulses
	output logic                    master_event_flag,
	output logic                    slave_event_flag
);
	// ==========================================================
	// reset and line synchronisers
	logic                rst_m_q, rst_n;
	logic                scl_m_q, scl_s, scl_p, sda_m_q, sda_s, sda_p;
	// release of reset is synchronised, assertion stays asynchronous
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rst_m_q <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n   <= rst_m_q;
		end
	end
	// two stages per line, a third copy for edge detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			{scl_m_q, scl_s, scl_p} <= 3'h7;
			{sda_m_q, sda_s, sda_p} <= 3'h7;
		end else begin
			{scl_m_q, scl_s, scl_p} <= {lines_in.scl, scl_m_q, scl_s};
			{sda_m_q, sda_s, sda_p} <= {lines_in.sda, sda_m_q, sda_s};
		end
	end
	wire scl_rise = scl_s && !scl_p;
	wire scl_fall = !scl_s && scl_p;
	wire start_det = scl_s && scl_p && sda_p && !sda_s;
	wire stop_det = scl_s && scl_p && !sda_p && sda_s;

	// ==========================================================
	// register port decode
	wire wr_tx   = req.we && req.addr == `A_TXBUF;
	wire wr_baud = req.we && req.addr == `A_BAUD;
	wire wr_ctrl = req.we && req.addr == `A_CTRL;
	wire wr_stat = req.we && req.addr == `A_STAT;
	wire wr_own  = req.we && req.addr == `A_OWN;
	wire rd_rx   = req.re && req.addr == `A_RXBUF;

	// ==========================================================
	// master engine
	i2cm_pkg::eng_state_t  state_q;
	logic [15:0]           ctrl_q, baud_q;
	logic [9:0]            own_q;
	logic [`BRG_W-1:0]     brg_q;
	logic [7:0]            txsh_q, rxsh_q;
	logic [2:0]            bit_q;
	logic                  m_scl_q, m_sda_q, tbf_q, master_transmit_active_q, ackstat_q;
	logic                  bcl_q, watch_q, m_evt_q, rx_load_q;
	logic [15:0]           req_ok, ctrl_new;
	// release phases wait for the line to really go high (other masters may stretch)
	wire hi_ph = state_q == i2cm_pkg::START_A || state_q == i2cm_pkg::RSTART_B ||
		state_q == i2cm_pkg::STOP_B || state_q == i2cm_pkg::TX_H ||
		state_q == i2cm_pkg::TXACK_H || state_q == i2cm_pkg::RX_H ||
		state_q == i2cm_pkg::ACK_H;
	wire counting = state_q != i2cm_pkg::IDLE && state_q != i2cm_pkg::WAIT;
	wire hold = hi_ph && !scl_s;
	wire tick = counting && !hold && brg_q == '0;
	wire coll = tick && !sda_s && (state_q == i2cm_pkg::START_A ||
		state_q == i2cm_pkg::RSTART_B || state_q == i2cm_pkg::STOP_C ||
		(state_q == i2cm_pkg::TX_H && txsh_q[7]) ||
		(state_q == i2cm_pkg::ACK_H && ctrl_q[`C_ACKDT]));
	wire tx_ok = state_q == i2cm_pkg::WAIT || (state_q == i2cm_pkg::IDLE && bcl_q);
	// request bits are only taken in the state that can serve them
	always_comb begin
		req_ok = 16'h0000;
		if (state_q == i2cm_pkg::IDLE)
			req_ok = `IDLE_REQ_M;
		else if (state_q == i2cm_pkg::WAIT)
			req_ok = `WAIT_REQ_M;
		ctrl_new = (req.wdata & `CFG_M) | (req.wdata & req_ok) | (ctrl_q & `REQ_M & ~req_ok); // [R12]
	end
	// sequencer, baud generator and shift registers share one timebase
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= i2cm_pkg::IDLE;
			ctrl_q    <= `CTRL_RST;
			baud_q    <= 16'h0000;
			own_q     <= 10'h000;
			brg_q     <= '0;
			txsh_q    <= `TX_RST;
			rxsh_q    <= 8'h00;
			bit_q     <= 3'h0;
			m_scl_q   <= 1'b0;
			m_sda_q   <= 1'b0;
			tbf_q     <= 1'b0;
			master_transmit_active_q  <= 1'b0;
			ackstat_q <= 1'b0;
			bcl_q     <= 1'b0;
			watch_q   <= 1'b0;
			m_evt_q   <= 1'b0;
			rx_load_q <= 1'b0;
		end else begin
			m_evt_q   <= 1'b0;
			rx_load_q <= 1'b0;
			if (wr_ctrl)
				ctrl_q <= ctrl_new;
			if (wr_baud)
				baud_q <= req.wdata;
			if (wr_own)
				own_q <= req.wdata[9:0];
			if (wr_stat && !req.wdata[`ST_BCL])
				bcl_q <= 1'b0;
			// count down to zero and rest there; a released clock held low reloads
			if (hold)
				brg_q <= baud_q; // [R16]
			else if (counting && brg_q != '0)
				brg_q <= brg_q - 1'b1; // [R14]
			if (wr_tx && tx_ok) begin
				txsh_q   <= req.wdata[7:0]; // [R21]
				tbf_q    <= 1'b1; // [R10]
				master_transmit_active_q <= 1'b1; // [R11]
				bit_q    <= 3'h0;
				m_scl_q  <= 1'b1;
				brg_q    <= baud_q;
				state_q  <= i2cm_pkg::TX_L;
			end
			unique case (state_q)
				i2cm_pkg::IDLE: if (ctrl_q[`C_START]) begin
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::START_A; // [R7]
				end
				i2cm_pkg::WAIT: if (!(wr_tx && tx_ok)) begin
					brg_q <= baud_q;
					if (ctrl_q[`C_RSTART]) begin
						m_sda_q <= 1'b0;
						state_q <= i2cm_pkg::RSTART_A;
					end else if (ctrl_q[`C_STOP]) begin
						m_sda_q <= 1'b1;
						state_q <= i2cm_pkg::STOP_A;
					end else if (ctrl_q[`C_ACKEN]) begin
						state_q <= i2cm_pkg::ACK_L;
					end else if (ctrl_q[`C_RCV]) begin
						bit_q   <= 3'h0;
						state_q <= i2cm_pkg::RX_L;
					end
				end
				i2cm_pkg::START_A: if (tick) begin
					m_sda_q <= 1'b1;
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::START_B;
				end
				i2cm_pkg::START_B: if (tick) begin
					m_scl_q <= 1'b1;
					ctrl_q[`C_START]  <= 1'b0;
					ctrl_q[`C_RSTART] <= 1'b0;
					m_evt_q <= 1'b1; // [R1]
					state_q <= i2cm_pkg::WAIT;
				end
				i2cm_pkg::RSTART_A: if (tick) begin
					m_scl_q <= 1'b0;
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::RSTART_B;
				end
				i2cm_pkg::RSTART_B: if (tick) begin
					m_sda_q <= 1'b1; // [R7]
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::START_B;
				end
				i2cm_pkg::STOP_A: if (tick) begin
					m_scl_q <= 1'b0;
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::STOP_B;
				end
				i2cm_pkg::STOP_B: if (tick) begin
					m_sda_q <= 1'b0;
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::STOP_C;
				end
				i2cm_pkg::STOP_C: if (tick) begin
					ctrl_q[`C_STOP] <= 1'b0;
					m_evt_q <= 1'b1;
					state_q <= i2cm_pkg::IDLE;
				end
				i2cm_pkg::TX_L: begin
					// data follows the falling clock by one cycle
					m_sda_q <= !txsh_q[7]; // [R11]
					if (tick) begin
						m_scl_q <= 1'b0;
						brg_q   <= baud_q;
						state_q <= i2cm_pkg::TX_H;
					end
				end
				i2cm_pkg::TX_H: if (tick) begin
					m_scl_q <= 1'b1; // [R13]
					brg_q   <= baud_q;
					txsh_q  <= {txsh_q[6:0], 1'b0};
					bit_q   <= bit_q + 3'h1; // [R8]
					if (bit_q == 3'h7) begin
						tbf_q   <= 1'b0;
						m_sda_q <= 1'b0;
						state_q <= i2cm_pkg::TXACK_L;
					end else
						state_q <= i2cm_pkg::TX_L;
				end
				i2cm_pkg::TXACK_L: if (tick) begin
					m_scl_q <= 1'b0;
					brg_q   <= baud_q;
					state_q <= i2cm_pkg::TXACK_H;
				end
				i2cm_pkg::TXACK_H: if (tick) begin
					ackstat_q <= sda_s; // [R8]
					master_transmit_active_q  <= 1'b0;
					m_scl_q   <= 1'b1;
					m_evt_q   <= 1'b1;
					state_q   <= i2cm_pkg::WAIT;
				end
				i2cm_pkg::RX_L: begin
					m_sda_q <= 1'b0;
					if (tick) begin
						m_scl_q <= 1'b0;
						brg_q   <= baud_q;
						state_q <= i2cm_pkg::RX_H;
					end
				end
				i2cm_pkg::RX_H: begin
					if (scl_rise)
						rxsh_q <= {rxsh_q[6:0], sda_s}; // [R13]
					if (tick) begin
						m_scl_q <= 1'b1;
						brg_q   <= baud_q;
						bit_q   <= bit_q + 3'h1;
						if (bit_q == 3'h7) begin
							rx_load_q <= 1'b1; // [R9]
							m_evt_q   <= 1'b1;
							ctrl_q[`C_RCV] <= 1'b0;
							state_q   <= i2cm_pkg::WAIT;
						end else
							state_q <= i2cm_pkg::RX_L;
					end
				end
				i2cm_pkg::ACK_L: begin
					m_sda_q <= !ctrl_q[`C_ACKDT]; // [R9]
					if (tick) begin
						m_scl_q <= 1'b0;
						brg_q   <= baud_q;
						state_q <= i2cm_pkg::ACK_H;
					end
				end
				i2cm_pkg::ACK_H: if (tick) begin
					m_scl_q <= 1'b1;
					ctrl_q[`C_ACKEN] <= 1'b0;
					m_evt_q <= 1'b1;
					state_q <= i2cm_pkg::WAIT;
				end
				default: state_q <= i2cm_pkg::IDLE;
			endcase
			// a stop seen after losing arbitration tells software the bus is free
			if (watch_q && stop_det) begin
				watch_q <= 1'b0;
				m_evt_q <= 1'b1; // [R20]
			end
			// lost arbitration: drop everything, lines released, set wins over clear
			if (coll) begin
				bcl_q    <= 1'b1; // [R17]
				watch_q  <= 1'b1;
				m_evt_q  <= 1'b1;
				tbf_q    <= 1'b0; // [R18]
				master_transmit_active_q <= 1'b0;
				m_scl_q  <= 1'b0;
				m_sda_q  <= 1'b0;
				ctrl_q   <= ctrl_q & ~`REQ_M; // [R19]
				state_q  <= i2cm_pkg::IDLE;
			end
			// clocks stop in sleep, so any transfer in flight is lost
			if (sleep) begin
				tbf_q    <= 1'b0; // [R22]
				master_transmit_active_q <= 1'b0;
				m_scl_q  <= 1'b0;
				m_sda_q  <= 1'b0;
				ctrl_q   <= ctrl_q & ~`REQ_M;
				state_q  <= i2cm_pkg::IDLE;
			end
		end
	end

	// ==========================================================
	// address monitor: general call and own address recognition
	logic [7:0] sm_sh_q;
	logic [3:0] sm_cnt_q;
	logic       sm_act_q, sm_gc_q, slv_ack_q, gc_load_q, gc_evt_q, s_evt_q;
	wire gc_hit = ctrl_q[`C_GENERAL_CALL_ENABLE] && sm_sh_q == 8'h00; // [R5]
	wire own_hit = ctrl_q[`C_ALLADDR] || sm_sh_q[7:1] == own_q[6:0]; // [R4]
	// only watches while this master is not driving the bus itself
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sm_sh_q   <= 8'h00;
			sm_cnt_q  <= 4'h0;
			sm_act_q  <= 1'b0;
			sm_gc_q   <= 1'b0;
			slv_ack_q <= 1'b0;
			gc_load_q <= 1'b0;
			gc_evt_q  <= 1'b0;
			s_evt_q   <= 1'b0;
		end else begin
			gc_load_q <= 1'b0;
			gc_evt_q  <= 1'b0;
			s_evt_q   <= 1'b0;
			if (sm_act_q && scl_rise && sm_cnt_q < 4'h8) begin
				sm_sh_q  <= {sm_sh_q[6:0], sda_s};
				sm_cnt_q <= sm_cnt_q + 4'h1;
			end
			if (sm_act_q && scl_fall && sm_cnt_q == 4'h8) begin
				if (gc_hit || own_hit) begin
					sm_gc_q   <= gc_hit;
					gc_load_q <= gc_hit; // [R6]
					slv_ack_q <= 1'b1;
					sm_cnt_q  <= 4'h9;
				end else
					sm_act_q <= 1'b0;
			end
			if (sm_act_q && scl_fall && sm_cnt_q == 4'h9) begin
				slv_ack_q <= 1'b0;
				gc_evt_q  <= sm_gc_q; // [R6]
				s_evt_q   <= !sm_gc_q; // [R2]
				sm_act_q  <= 1'b0;
			end
			if (start_det && state_q == i2cm_pkg::IDLE) begin
				sm_act_q <= 1'b1;
				sm_cnt_q <= 4'h0;
			end
			if (stop_det || sleep || state_q != i2cm_pkg::IDLE) begin
				sm_act_q  <= 1'b0;
				slv_ack_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// receive buffer, bus status, events and pins
	logic [7:0] rxbuf_q;
	logic       rbf_q, bus_s_q, bus_p_q;
	// a load in the cycle of a buffer read keeps the flag set
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rxbuf_q <= 8'h00;
			rbf_q   <= 1'b0;
		end else begin
			if (rd_rx)
				rbf_q <= 1'b0;
			if (rx_load_q || gc_load_q) begin
				rxbuf_q <= rx_load_q ? rxsh_q : sm_sh_q;
				rbf_q   <= 1'b1; // [R6]
			end
		end
	end
	// start and stop seen on the bus
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_s_q <= 1'b0;
			bus_p_q <= 1'b0;
		end else if (start_det) begin
			bus_s_q <= 1'b1;
			bus_p_q <= 1'b0;
		end else if (stop_det) begin
			bus_s_q <= 1'b0;
			bus_p_q <= 1'b1;
		end
	end
	// outputs registered; open drain so the data level is always low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lines_out            <= '0;
			slew_control_disable <= 1'b0;
			master_event_flag    <= 1'b0;
			slave_event_flag     <= 1'b0;
		end else begin
			lines_out.scl_oe     <= m_scl_q;
			lines_out.sda_oe     <= m_sda_q || slv_ack_q; // [R4]
			slew_control_disable <= ctrl_q[`C_SLEW]; // [R3]
			master_event_flag    <= m_evt_q || gc_evt_q; // [R23]
			slave_event_flag     <= s_evt_q; // [R23]
		end
	end
	// read data appear only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rdata <= 16'h0000;
		else if (!req.re)
			rdata <= 16'h0000;
		else begin
			unique case (req.addr)
				`A_RXBUF: rdata <= {8'h00, rxbuf_q};
				`A_TXBUF: rdata <= {8'h00, txsh_q};
				`A_BAUD:  rdata <= baud_q;
				`A_CTRL:  rdata <= ctrl_q;
				`A_STAT:  rdata <= {ackstat_q, master_transmit_active_q, 3'h0, bcl_q, 5'h00, bus_p_q,
					bus_s_q, 1'b0, rbf_q, tbf_q};
				`A_OWN:   rdata <= {6'h00, own_q};
				default:  rdata <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// checks
	sequence tx_launch;
		wr_tx && state_q == i2cm_pkg::WAIT && !sleep;
	endsequence
	sequence coll_seen;
		coll && !sleep;
	endsequence
	a_tx_launch_flags: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
		tx_launch |=> tbf_q && master_transmit_active_q && state_q == i2cm_pkg::TX_L)
		else $error("transmit write did not launch");
	a_master_transmit_active_held: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
		(state_q == i2cm_pkg::TX_L || state_q == i2cm_pkg::TX_H) |-> master_transmit_active_q)
		else $error("transmit active low during shifting");
	a_rcv_ignored: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
		wr_ctrl && req.wdata[`C_RCV] && state_q != i2cm_pkg::WAIT && !ctrl_q[`C_RCV]
		|=> !ctrl_q[`C_RCV])
		else $error("receive enable taken while busy");
	a_brg_countdown: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
		counting && !hold && brg_q != '0 && !wr_tx && !coll && !sleep
		|=> brg_q == $past(brg_q) - 1'b1)
		else $error("baud generator did not count down");
	a_arb_reload: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
		hold && !coll && !sleep |=> brg_q == baud_q || state_q != $past(state_q))
		else $error("baud generator ran while clock held low");
	a_coll_release: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
		coll_seen |=> state_q == i2cm_pkg::IDLE && bcl_q && !tbf_q
		##1 !lines_out.scl_oe && master_event_flag)
		else $error("collision not handled");
	a_coll_req_clr: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
		coll_seen |=> (ctrl_q & `REQ_M) == 16'h0000)
		else $error("request bits survive a collision");
	a_gc_load: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
		gc_load_q && !rx_load_q |=> rbf_q && rxbuf_q == 8'h00)
		else $error("general call byte not buffered");
	a_event_pulse: assert property (@(posedge clock) disable iff (!rst_n) // [R23]
		$rose(slave_event_flag) |=> !slave_event_flag)
		else $error("slave event longer than one cycle");
	a_sleep_abort: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
		sleep |=> state_q == i2cm_pkg::IDLE && !tbf_q ##1 !lines_out.scl_oe)
		else $error("sleep did not abort");
	a_rx_sample: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
		state_q == i2cm_pkg::RX_H && scl_rise && !sleep
		|=> rxsh_q[0] == $past(sda_s))
		else $error("receive bit not sampled on rising clock");
endmodule

// >>> verilog/i2cm_cfg.svh
// register map, field positions and reset values of the i2c master engine
//
// Functional notes
// [R1] master event flag pulses when a start, stop, byte, ack or collision step ends
// [R2] slave event flag pulses when a bus address selects this device
// [R3] slew control disable bit turns off edge-rate limiting; needed at 1 MHz
// [R4] accept-all-addresses bit makes every received address a match
// [R5] general call enable compares each address byte also with all-zero write address
// [R6] general call: byte to receive buffer after clock eight, full flag, event at ninth fall
// [R7] master makes every clock pulse, start and stop; repeated start keeps the bus
// [R8] master transmit sends address byte, eight bits per byte, samples acknowledge
// [R9] master receive takes eight bits per byte, then drives acknowledge bit
// [R10] transmit buffer write only while waiting; sets full flag and launches shifting
// [R11] data changes after falling clock; transmit-active status bit 14 set meanwhile
// [R12] receive enable bit 11 starts reception only when idle, else ignored; the engine takes it only in WAIT and ignores it in IDLE
// [R13] each baud rollover toggles clock; data sampled on rising clock
// [R14] baud generator loads reload value, counts to 0, then stops
// [R15] software programs reload value of at least 2; clock period is 2 x (reload + 1) cycles plus line sync delay
// [R16] released clock stalls baud count until clock seen high, then reload
// [R17] sda low while expecting high flags collision, event, master to idle
// [R18] collision in transmit clears full flag, releases lines, accepts new write
// [R19] collision in start, restart, stop or ack aborts it and clears its request bit
// [R20] after collision, a stop seen on the bus raises the master event flag
// [R21] transmit write after collision shifts from the first bit of the new byte
// [R22] sleep stops the engine and aborts any transfer in progress
// [R23] each event flag is a one-cycle pulse, once per bus event
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH
`define A_RXBUF    10'h200
`define A_TXBUF    10'h202
`define A_BAUD     10'h204
`define A_CTRL     10'h206
`define A_STAT     10'h208
`define A_OWN      10'h20A
`define C_GENERAL_CALL_ENABLE     15
`define C_ALLADDR  12
`define C_RCV      11
`define C_SLEW     9
`define C_ACKDT    5
`define C_ACKEN    4
`define C_STOP     2
`define C_RSTART   1
`define C_START    0
`define CFG_M      16'h9220
`define REQ_M      16'h0817
`define IDLE_REQ_M 16'h0001
`define WAIT_REQ_M 16'h0816
`define ST_ACKSTAT 15
`define ST_MASTER_TRANSMIT_ACTIVE  14
`define ST_BCL     10
`define ST_STOP    4
`define ST_START   3
`define ST_RBF     1
`define ST_TBF     0
`define TX_RST     8'hFF
`define CTRL_RST   16'h0000
`define BRG_W      16
`endif

// >>> verilog/i2cm_pkg.sv
// shared types of the i2c master engine
package i2cm_pkg;
	typedef enum logic [4:0] {
		IDLE, WAIT, START_A, START_B, RSTART_A, RSTART_B, STOP_A, STOP_B, STOP_C,
		TX_L, TX_H, TXACK_L, TXACK_H, RX_L, RX_H, ACK_L, ACK_H
	} eng_state_t;
	typedef struct packed {
		logic [9:0]  addr;
		logic [15:0] wdata;
		logic        we;
		logic        re;
	} reg_req_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} line_in_t;
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} line_out_t;
endpackage

// >>> tb/i2c_slave_model.sv
// slave device model on the two-wire bus: acks its address, returns a byte on reads
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// clock and bus levels
	input  wire logic       clock,
	input  wire logic       scl,
	input  wire logic       sda,
	// test controls
	input  wire logic [7:0] tx_byte,
	input  wire logic       stretch,
	input  wire logic       collide,
	// line pull-downs
	output logic            scl_pull,
	output logic            sda_pull
);
	logic       scl_q = 1'b1;
	logic       sda_q = 1'b1;
	logic       first = 1'b0;
	logic       rd    = 1'b0;
	logic       act   = 1'b0;
	logic       dpull = 1'b0;
	logic [3:0] cnt   = 4'h0;
	logic [7:0] sh    = 8'h00;
	logic [4:0] hold  = 5'h00;

	// collide makes a low the master does not expect; hold stretches the low clock
	assign sda_pull = dpull | collide;
	assign scl_pull = hold != 5'h00;

	// ==========================================================
	// bus follower: start resets, rises shift in, falls move the data line
	always @(posedge clock) begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 5'h00) begin
			hold <= hold - 5'h01;
		end
		if (scl_q && scl && sda_q && !sda) begin
			cnt   <= 4'h0;
			first <= 1'b1;
			rd    <= 1'b0;
			dpull <= 1'b0;
		end else if (!scl_q && scl) begin
			cnt <= cnt + 4'h1;
			sh  <= {sh[6:0], sda};
		end else if (scl_q && !scl) begin
			if (stretch) begin
				hold <= 5'h0C;
			end
			if (cnt == 4'h8) begin
				// only the addressed slave acks; a read byte is left to the master
				dpull <= first ? (sh[7:1] == DEV_ADDR) : (act && !rd);
				if (first) begin
					act <= sh[7:1] == DEV_ADDR;
					rd  <= sh[0] && (sh[7:1] == DEV_ADDR);
				end
			end else if (cnt == 4'h9) begin
				cnt   <= 4'h0;
				first <= 1'b0;
				dpull <= rd && !tx_byte[7];
			end else begin
				dpull <= rd && (cnt != 4'h0) && !tx_byte[3'h7 - cnt[2:0]];
			end
		end
	end
endmodule

// >>> tb/tb.sv
// testbench of the i2c master engine against a slave model on the bus
`timescale 1ns/1ps
`include "i2cm_cfg.svh"
module tb;
	logic                clock, resetn, sleep, stretch, collide, m_scl, m_sda;
	i2cm_pkg::reg_req_t  req;
	i2cm_pkg::line_in_t  li;
	i2cm_pkg::line_out_t lo;
	logic [15:0]         rdata, d;
	logic                slew, mev, sev, scl, sda, s_scl, s_sda, scl_p;
	logic [8:0]          mon_sh;
	int                  err_total, n_checks, mev_n, sev_n, hi_n, lo_n, hi_min, lo_min;

	// open-drain bus with pull-ups: low while any party pulls
	assign scl = !(lo.scl_oe | s_scl | m_scl);
	assign sda = !(lo.sda_oe | s_sda | m_sda);
	assign li  = {scl, sda};

	i2c_master_engine i2c_master_engine_i (
		.clock(clock), .resetn(resetn), .req(req), .rdata(rdata), .sleep(sleep),
		.lines_in(li), .lines_out(lo), .slew_control_disable(slew),
		.master_event_flag(mev), .slave_event_flag(sev));
	i2c_slave_model i2c_slave_model_i (
		.clock(clock), .scl(scl), .sda(sda), .tx_byte(8'hC3), .stretch(stretch),
		.collide(collide), .scl_pull(s_scl), .sda_pull(s_sda));

	// ==========================================================
	// bus watcher at mid-cycle: event counts, shifted bits, clock phase widths
	always @(negedge clock) begin
		mev_n += mev;
		sev_n += sev;
		if (scl && !scl_p) mon_sh = {mon_sh[7:0], sda};
		if (scl !== scl_p) begin
			if (scl_p && hi_n < hi_min) hi_min = hi_n;
			if (!scl_p && lo_n < lo_min) lo_min = lo_n;
			hi_n = 0;
			lo_n = 0;
		end
		if (scl) hi_n++; else lo_n++;
		scl_p = scl;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [15:0] v);
		@(posedge clock);
		req <= '{a, v, 1'b1, 1'b0};
		@(posedge clock);
		req.we <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a);
		@(posedge clock);
		req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clock);
		req.re <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait for one more master event, then exactly one pulse
	task automatic wait_mev(input int n0);
		int k;
		k = 0;
		while (mev_n == n0 && k < 3000) begin
			@(posedge clock);
			k++;
		end
		repeat (4) @(posedge clock);
		chk("master event count", 16'(mev_n - n0), 16'h0001);
	endtask
	task automatic op(input logic [9:0] a, input logic [15:0] v);
		int n0;
		n0 = mev_n;
		wr(a, v);
		wait_mev(n0);
	endtask
	task automatic send(input logic [7:0] b);
		int n0;
		n0 = mev_n;
		wr(`A_TXBUF, {8'h00, b});
		rd(`A_STAT);
		chk("busy flags", d & 16'h4001, 16'h4001);
		wait_mev(n0);
		chk("byte on bus", mon_sh[8:1], b);
		rd(`A_STAT);
		chk("ack and full", d & 16'hC001, 16'h0000);
	endtask
	// another master on the bus: start, eight bits, ninth clock, stop
	task automatic ext_frame(input logic [7:0] b, output logic ack);
		logic [8:0] s;
		s = {b, 1'b1};
		m_sda <= 1'b1;
		repeat (10) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			m_scl <= 1'b1;
			repeat (5) @(posedge clock);
			m_sda <= !s[8];
			s = s << 1;
			repeat (5) @(posedge clock);
			m_scl <= 1'b0;
			repeat (5) @(posedge clock);
			#1 ack = sda;
			repeat (5) @(posedge clock);
		end
		m_scl <= 1'b1;
		m_sda <= 1'b1;
		repeat (5) @(posedge clock);
		m_scl <= 1'b0;
		repeat (10) @(posedge clock);
		m_sda <= 1'b0;
		repeat (20) @(posedge clock);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		wr(`A_BAUD, 16'h0003);
		wr(`A_CTRL, 16'h0200);
		rd(`A_CTRL);
		chk("control", d, 16'h0200);
		chk("slew disable", slew, 16'h0001);
		rd(10'h20C);
		chk("unmapped read", d, 16'h0000);
		wr(`A_CTRL, 16'h0800);
		rd(`A_CTRL);
		chk("receive in idle", d, 16'h0000);
		wr(`A_TXBUF, 16'h0012);
		rd(`A_STAT);
		chk("transmit in idle", d & 16'h4001, 16'h0000);
	endtask
	task automatic t_write();
		stretch <= 1'b1;
		hi_min = 1000;
		lo_min = 1000;
		op(`A_CTRL, 16'h0001);
		send(8'h54);
		send(8'hA5);
		// repeated start: bus stays claimed, start seen, no stop in between
		op(`A_CTRL, 16'h0002);
		rd(`A_STAT);
		chk("restart holds bus", d & 16'h0018, 16'h0008);
		op(`A_CTRL, 16'h0004);
		chk("lines free", {lo.scl_oe, lo.sda_oe}, 16'h0000);
		chk("scl high span", 16'(hi_min >= 4), 16'h0001);
		chk("scl low span", 16'(lo_min >= 4), 16'h0001);
		stretch <= 1'b0;
	endtask
	task automatic t_read();
		op(`A_CTRL, 16'h0001);
		send(8'h55);
		op(`A_CTRL, 16'h0800);
		rd(`A_STAT);
		chk("receive full", d & 16'h0002, 16'h0002);
		rd(`A_RXBUF);
		chk("received byte", d, 16'h00C3);
		op(`A_CTRL, 16'h0010);
		chk("ack driven", mon_sh[0], 16'h0000);
		op(`A_CTRL, 16'h0004);
	endtask
	task automatic t_gencall();
		logic a;
		int   m0, s0;
		wr(`A_CTRL, 16'h8000);
		m0 = mev_n;
		s0 = sev_n;
		ext_frame(8'h00, a);
		chk("general call ack", a, 16'h0000);
		chk("general call events", 16'(mev_n - m0), 16'h0001);
		chk("no slave event", 16'(sev_n - s0), 16'h0000);
		rd(`A_STAT);
		chk("general call full", d & 16'h0002, 16'h0002);
		rd(`A_RXBUF);
		chk("general call byte", d, 16'h0000);
		wr(`A_CTRL, 16'h1000);
		m0 = mev_n;
		s0 = sev_n;
		ext_frame(8'h62, a);
		chk("any address ack", a, 16'h0000);
		chk("slave events", 16'(sev_n - s0), 16'h0001);
		chk("no master event", 16'(mev_n - m0), 16'h0000);
		wr(`A_CTRL, 16'h0000);
	endtask
	task automatic t_collide();
		int n0;
		op(`A_CTRL, 16'h0001);
		collide <= 1'b1;
		op(`A_TXBUF, 16'h00FF);
		rd(`A_STAT);
		chk("collision status", d & 16'h4401, 16'h0400);
		chk("lines freed", {lo.scl_oe, lo.sda_oe}, 16'h0000);
		n0 = mev_n;
		collide <= 1'b0;
		wait_mev(n0);
		mon_sh = 9'h000;
		op(`A_TXBUF, 16'h003C);
		chk("restart from first bit", mon_sh[8:1], 16'h003C);
		collide <= 1'b1;
		op(`A_CTRL, 16'h0004);
		rd(`A_CTRL);
		chk("stop request cleared", d & 16'h0004, 16'h0000);
		chk("lines freed", {lo.scl_oe, lo.sda_oe}, 16'h0000);
		n0 = mev_n;
		collide <= 1'b0;
		wait_mev(n0);
		wr(`A_STAT, 16'h0000);
	endtask
	task automatic t_sleep();
		op(`A_CTRL, 16'h0001);
		wr(`A_TXBUF, 16'h0054);
		repeat (20) @(posedge clock);
		sleep <= 1'b1;
		repeat (5) @(posedge clock);
		sleep <= 1'b0;
		rd(`A_STAT);
		chk("aborted transfer", d & 16'h4001, 16'h0000);
		chk("lines after sleep", {lo.scl_oe, lo.sda_oe}, 16'h0000);
	endtask

	task automatic print_verdict();
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ==========================================================
	// clock, reset, sequence and watchdog
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		{resetn, sleep, stretch, collide, m_scl, m_sda} = 6'h00;
		req = '0;
		mon_sh = 9'h000;
		scl_p = 1'b1;
		{err_total, n_checks, mev_n, sev_n, hi_n, lo_n} = '0;
		hi_min = 1000;
		lo_min = 1000;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		repeat (3) @(posedge clock);
		t_regs();
		t_write();
		t_read();
		t_gencall();
		t_collide();
		t_sleep();
		print_verdict();
	end
	// the whole run needs well under 10000 cycles
	initial begin
		#3000000;
		err_total++;
		print_verdict();
	end
endmodule
